// ### shared/mss_pkg.sv
package mss_pkg;

    // Module state encodings as reported to the host
    typedef enum logic [2:0] {
        MSS_RESETTING  = 3'h0,
        MSS_RESET      = 3'h1,
        MSS_MGMT_INIT  = 3'h2,
        MSS_LOW_PWR    = 3'h3,
        MSS_PWR_UP     = 3'h4,
        MSS_READY      = 3'h5,
        MSS_PWR_DN     = 3'h6,
        MSS_FAULT      = 3'h7
    } mss_state_t;

    // Management-initialisation time limit in microseconds
    localparam int unsigned MGMT_INIT_TIME_US = 2000;
    // Clock rate in kHz
    localparam int unsigned CLK_KHZ           = 25000;
    // Longest time rounds down to whole cycles
    localparam int unsigned MGMT_INIT_CYCLES  =
        (MGMT_INIT_TIME_US * CLK_KHZ) / 1000;
    // Width of the init timer
    localparam int unsigned TMR_W             = 24;
    // Synchroniser depth for pin inputs
    localparam int unsigned SYNC_STAGES       = 3;

    // Reset sources bundled together
    typedef struct packed {
        logic supply_low_reset;    // Supply monitor asserted
        logic reset_pin;           // Hardware reset pin asserted
        logic software_reset_bit;  // Software reset request
    } mss_rst_src_t;

    // Low-power request controls
    typedef struct packed {
        logic sw_low_power_request; // Software low-power bit
        logic hw_request_allowed;   // Pin request allowed
        logic hw_low_power_pin;     // Hardware low-power pin
    } mss_lp_src_t;

    // Power and reset controls driven toward the module
    typedef struct packed {
        logic high_power;       // High power mode enabled
        logic mgmt_in_reset;    // Management interface in reset
        logic elec_in_reset;    // Module electronics in reset
        logic mgmt_ready;       // Management memory accessible
    } mss_ctrl_t;

endpackage

// ### core/mss_sync.sv
`timescale 1ns/1ps
// Three-flop synchroniser; change accepted when stages two and three agree
module mss_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] s1_q;   // Metastability catcher, read only by s2
    logic [W-1:0] s2_q;   // Second stage
    logic [W-1:0] s3_q;   // Third stage

    // Shift chain
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Filtered output per bit
    genvar gi;
    generate
        for (gi = 0; gi < W; gi++) begin : g_bit
            always_ff @(posedge sys_clk_i) begin
                if (!rst_n_i) begin
                    sync_o[gi] <= 1'b0;
                end else if (s2_q[gi] == s3_q[gi]) begin
                    sync_o[gi] <= s3_q[gi];
                end
            end
        end
    endgenerate
endmodule // mss_sync

// ### core/mss_sequencer.sv
`timescale 1ns/1ps
// How it works
// - Resetting drives management and electronics into reset
// - Reset holds all in reset until condition clears
// - Reset condition sends active states to resetting
// - Fault condition sends paged active states to fault
// - Management init powers management at low power
// - Management ready goes idle; sets flag only if low-power term holds
// - Init must finish within the time limit
// - Idle at low power; request drop starts power-up
// - Power-up high power; request down or ready
// - Ready draws full power; exit term powers down
// - Powering-down returns to idle once low power
// - Fault holds low power, leaves only by reset
// - Flat module reaches ready without host help
// - Flat module hides resetting, reset, init states
// - Flat module always reports fully-ready
// - Flat reset pin may hold memory; data stays
// - Flat module ignores software and supply combined_reset_condition
// - Flat module starts in the reset state
// - Flat init ends after time limit elapses
// - Flat ready stays low power until reset
// - Flat resetting combined_reset_condition management then reset state
// - Reset condition ORs supply, pin and software
// - Reset beats fault beats all other exits
// - Low-power term: software OR allowed-and-pin
// - Exit term: request and all lanes deactivated
module mss_sequencer #(
    parameter bit          FLAT_MEMORY = 1'b0, // Flat-memory variant
    parameter int unsigned LANES       = 8,    // Host lane count
    parameter int unsigned INIT_CYCLES = mss_pkg::MGMT_INIT_CYCLES
) (
    input  wire logic                 sys_clk_i,
    input  wire logic                 rst_n_i,
    input  mss_pkg::mss_rst_src_t     rst_src_i,       // Reset sources
    input  wire logic                 fault_condition_i,
    input  mss_pkg::mss_lp_src_t      lp_src_i,        // Low-power controls
    input  wire logic [LANES-1:0]     lane_path_deactivated_i,
    input  wire logic                 mgmt_if_ready_i, // Init complete
    input  wire logic                 pwr_up_done_i,   // Power-up complete
    input  wire logic                 pwr_dn_done_i,   // Back at low power
    input  wire logic                 resetting_done_i,// Shutdown complete
    input  wire logic                 flag_clear_i,    // Host clears flag
    output mss_pkg::mss_state_t       module_state_o,  // Reported state
    output logic                      state_change_flag_o,
    output mss_pkg::mss_ctrl_t        ctrl_o,          // Power/reset controls
    output logic                      data_path_active_o,
    output logic                      init_overrun_o   // Init time exceeded
);
    // Pin inputs pass the synchroniser; internal terms do not
    localparam int unsigned PW = 4;
    logic [PW-1:0] pin_raw;   // Raw asynchronous pins
    logic [PW-1:0] pin_s;     // Synchronised pins
    logic          sup_low_s; // Supply low, synchronised
    logic          rst_pin_s; // Reset pin, synchronised
    logic          hw_lp_s;   // Low-power pin, synchronised
    logic          fault_s;   // Fault, synchronised

    assign pin_raw = {rst_src_i.supply_low_reset, rst_src_i.reset_pin,
                      lp_src_i.hw_low_power_pin, fault_condition_i};

    mss_sync #(
        .W (PW)
    ) u_sync (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .async_i   (pin_raw),
        .sync_o    (pin_s)
    );

    assign sup_low_s = pin_s[3];
    assign rst_pin_s = pin_s[2];
    assign hw_lp_s   = pin_s[1];
    assign fault_s   = pin_s[0];

    // Transition signals
    logic combined_reset_condition;  // Reset request
    logic low_power_request_term;    // Low-power request
    logic all_lanes_deactivated;     // Every lane deactivated
    logic low_power_exit_term;       // Ready exit term

    // Flat modules ignore software and supply combined_reset_condition
    always_comb begin
        if (FLAT_MEMORY) begin
            combined_reset_condition = rst_pin_s;
        end else begin
            combined_reset_condition = sup_low_s | rst_pin_s |
                rst_src_i.software_reset_bit;
        end
    end

    assign low_power_request_term = lp_src_i.sw_low_power_request |
        (lp_src_i.hw_request_allowed & hw_lp_s);
    assign all_lanes_deactivated = &lane_path_deactivated_i;
    assign low_power_exit_term = low_power_request_term &
        all_lanes_deactivated;

    // State register and init timer
    mss_pkg::mss_state_t     state_q;  // Conceptual state
    mss_pkg::mss_state_t     state_d;  // Next state
    logic [mss_pkg::TMR_W-1:0] tmr_q;  // Cycles spent in init
    logic                      tmr_done; // Init time reached

    assign tmr_done = (tmr_q >= mss_pkg::TMR_W'(INIT_CYCLES - 1));

    // Next-state logic; reset first, fault second, others last
    always_comb begin
        state_d = state_q;
        case (state_q)
            mss_pkg::MSS_RESETTING: begin
                if (resetting_done_i) begin
                    state_d = mss_pkg::MSS_RESET;
                end
            end
            mss_pkg::MSS_RESET: begin
                if (!combined_reset_condition) begin
                    state_d = mss_pkg::MSS_MGMT_INIT;
                end
            end
            mss_pkg::MSS_MGMT_INIT: begin
                if (combined_reset_condition) begin
                    state_d = mss_pkg::MSS_RESETTING;
                end else if (FLAT_MEMORY) begin
                    if (tmr_done) begin
                        state_d = mss_pkg::MSS_READY;
                    end
                end else if (fault_s) begin
                    state_d = mss_pkg::MSS_FAULT;
                end else if (mgmt_if_ready_i) begin
                    state_d = mss_pkg::MSS_LOW_PWR;
                end
            end
            mss_pkg::MSS_LOW_PWR: begin
                if (combined_reset_condition) begin
                    state_d = mss_pkg::MSS_RESETTING;
                end else if (fault_s) begin
                    state_d = mss_pkg::MSS_FAULT;
                end else if (!low_power_request_term) begin
                    state_d = mss_pkg::MSS_PWR_UP;
                end
            end
            mss_pkg::MSS_PWR_UP: begin
                if (combined_reset_condition) begin
                    state_d = mss_pkg::MSS_RESETTING;
                end else if (fault_s) begin
                    state_d = mss_pkg::MSS_FAULT;
                end else if (low_power_request_term) begin
                    state_d = mss_pkg::MSS_PWR_DN;
                end else if (pwr_up_done_i) begin
                    state_d = mss_pkg::MSS_READY;
                end
            end
            mss_pkg::MSS_READY: begin
                if (combined_reset_condition) begin
                    state_d = mss_pkg::MSS_RESETTING;
                end else if (FLAT_MEMORY) begin
                    state_d = mss_pkg::MSS_READY;
                end else if (fault_s) begin
                    state_d = mss_pkg::MSS_FAULT;
                end else if (low_power_exit_term) begin
                    state_d = mss_pkg::MSS_PWR_DN;
                end
            end
            mss_pkg::MSS_PWR_DN: begin
                if (combined_reset_condition) begin
                    state_d = mss_pkg::MSS_RESETTING;
                end else if (fault_s) begin
                    state_d = mss_pkg::MSS_FAULT;
                end else if (pwr_dn_done_i) begin
                    state_d = mss_pkg::MSS_LOW_PWR;
                end
            end
            mss_pkg::MSS_FAULT: begin
                // Only reset or removal of power leaves here
                if (combined_reset_condition) begin
                    state_d = mss_pkg::MSS_RESETTING;
                end
            end
            default: begin
                state_d = mss_pkg::MSS_RESETTING;
            end
        endcase
    end

    // State update; power-on starts in reset
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state_q <= mss_pkg::MSS_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // Init timer counts from entry into management init
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            tmr_q <= '0;
        end else if (state_q != mss_pkg::MSS_MGMT_INIT) begin
            tmr_q <= '0;
        end else if (!tmr_done) begin
            tmr_q <= tmr_q + 1'b1;
        end
    end

    // Overrun flag: paged init not finished in time
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            init_overrun_o <= 1'b0;
        end else if (!FLAT_MEMORY && state_q == mss_pkg::MSS_MGMT_INIT &&
                     tmr_done && state_d == mss_pkg::MSS_MGMT_INIT) begin
            init_overrun_o <= 1'b1;
        end else if (state_q == mss_pkg::MSS_RESET) begin
            init_overrun_o <= 1'b0;
        end
    end

    // Flag-worthy entry that is not left at once
    logic flag_set;
    always_comb begin
        flag_set = 1'b0;
        if (state_d != state_q) begin
            case (state_d)
                mss_pkg::MSS_LOW_PWR: begin
                    flag_set = low_power_request_term;
                end
                mss_pkg::MSS_READY: begin
                    flag_set = !FLAT_MEMORY;
                end
                mss_pkg::MSS_FAULT: begin
                    flag_set = 1'b1;
                end
                default: begin
                    flag_set = 1'b0;
                end
            endcase
        end
    end

    // Sticky flag; a set in the clear cycle wins
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state_change_flag_o <= 1'b0;
        end else if (flag_set) begin
            state_change_flag_o <= 1'b1;
        end else if (flag_clear_i ||
                     state_q == mss_pkg::MSS_RESET) begin
            state_change_flag_o <= 1'b0;
        end
    end

    // Reported state; flat modules always report ready
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            module_state_o <= FLAT_MEMORY ? mss_pkg::MSS_READY
                                          : mss_pkg::MSS_RESET;
        end else if (FLAT_MEMORY) begin
            module_state_o <= mss_pkg::MSS_READY;
        end else begin
            module_state_o <= state_d;
        end
    end

    // Power and reset controls follow the next state
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            ctrl_o <= '{high_power: 1'b0, mgmt_in_reset: 1'b1,
                        elec_in_reset: 1'b1, mgmt_ready: 1'b0};
        end else begin
            // High power only in power-up, ready, power-down (paged)
            ctrl_o.high_power <= !FLAT_MEMORY &&
                (state_d == mss_pkg::MSS_PWR_UP ||
                 state_d == mss_pkg::MSS_READY ||
                 state_d == mss_pkg::MSS_PWR_DN);
            ctrl_o.mgmt_in_reset <= state_d == mss_pkg::MSS_RESETTING ||
                state_d == mss_pkg::MSS_RESET;
            // Flat modules only reset the memory, not electronics
            ctrl_o.elec_in_reset <= !FLAT_MEMORY &&
                (state_d == mss_pkg::MSS_RESETTING ||
                 state_d == mss_pkg::MSS_RESET);
            ctrl_o.mgmt_ready <= state_d != mss_pkg::MSS_RESETTING &&
                state_d != mss_pkg::MSS_RESET &&
                state_d != mss_pkg::MSS_MGMT_INIT;
        end
    end

    // Data path stays active on flat modules throughout
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            data_path_active_o <= FLAT_MEMORY;
        end else begin
            data_path_active_o <= FLAT_MEMORY ||
                state_d == mss_pkg::MSS_READY;
        end
    end

    // Checks
    chk_reset_wins: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (combined_reset_condition && state_q != mss_pkg::MSS_RESET &&
         state_q != mss_pkg::MSS_RESETTING)
        |=> state_q == mss_pkg::MSS_RESETTING)
        else $error("reset condition did not enter resetting");

    chk_fault_enter: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (!FLAT_MEMORY && fault_s && !combined_reset_condition &&
         state_q inside {mss_pkg::MSS_MGMT_INIT, mss_pkg::MSS_LOW_PWR,
                         mss_pkg::MSS_PWR_UP, mss_pkg::MSS_READY,
                         mss_pkg::MSS_PWR_DN})
        |=> state_q == mss_pkg::MSS_FAULT)
        else $error("fault condition did not enter fault");

    chk_reset_hold: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (state_q == mss_pkg::MSS_RESET && combined_reset_condition)
        |=> state_q == mss_pkg::MSS_RESET && ctrl_o.mgmt_in_reset)
        else $error("reset state left or management not in reset");

    chk_lowpwr_up: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (state_q == mss_pkg::MSS_LOW_PWR && !combined_reset_condition &&
         !fault_s && !low_power_request_term)
        |=> state_q == mss_pkg::MSS_PWR_UP && ctrl_o.high_power)
        else $error("idle did not start power-up");

    chk_ready_exit: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (!FLAT_MEMORY && state_q == mss_pkg::MSS_READY &&
         !combined_reset_condition && !fault_s && low_power_request_term &&
         !all_lanes_deactivated)
        |=> state_q == mss_pkg::MSS_READY)
        else $error("ready left with lanes still active");

    chk_flag_idle: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (!FLAT_MEMORY && state_q == mss_pkg::MSS_MGMT_INIT &&
         $past(state_q) == mss_pkg::MSS_MGMT_INIT && !combined_reset_condition &&
         !fault_s && mgmt_if_ready_i && low_power_request_term)
        |=> state_change_flag_o)
        else $error("state change flag not set on idle entry");

    chk_flat_report: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        FLAT_MEMORY |-> module_state_o == mss_pkg::MSS_READY)
        else $error("flat module reported other than ready");

    chk_flat_init: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (FLAT_MEMORY && state_q == mss_pkg::MSS_MGMT_INIT && tmr_done &&
         !combined_reset_condition)
        |=> state_q == mss_pkg::MSS_READY && ctrl_o.mgmt_ready)
        else $error("flat module did not reach ready after init time");

    chk_fault_stay: assert property (@(posedge sys_clk_i)
        disable iff (!rst_n_i)
        (state_q == mss_pkg::MSS_FAULT && !combined_reset_condition)
        |=> state_q == mss_pkg::MSS_FAULT && !ctrl_o.high_power)
        else $error("fault state left without reset");

    cov_ready: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        state_q == mss_pkg::MSS_READY);
    cov_pwr_dn: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        state_q == mss_pkg::MSS_PWR_DN ##1 state_q == mss_pkg::MSS_LOW_PWR);
    cov_fault: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        state_q == mss_pkg::MSS_FAULT);
    cov_reset: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        state_q == mss_pkg::MSS_RESETTING ##1 state_q == mss_pkg::MSS_RESET);
endmodule // mss_sequencer

// ### testbench/mss_host_model.sv
`timescale 1ns/1ps
// Host side: acknowledges the state-change flag after a short delay
module mss_host_model #(
    parameter int unsigned INIT_CYCLES = 16 // Init time in cycles
) (
    input  wire logic sys_clk_i,
    input  wire logic rst_n_i,
    input  wire logic state_change_flag_i,
    output logic      flag_clear_o
);
    int unsigned up_q;  // Cycles since reset release
    int unsigned lag_q; // Delay before acknowledging

    // Host keeps off the module until the init period has run
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            up_q <= 0;
        end else if (up_q < INIT_CYCLES) begin
            up_q <= up_q + 1;
        end
    end

    // Slow acknowledge so the bench can see the flag stand
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i || !state_change_flag_i || up_q < INIT_CYCLES) begin
            lag_q        <= 0;
            flag_clear_o <= 1'b0;
        end else begin
            lag_q        <= lag_q + 1;
            flag_clear_o <= (lag_q == 3);
        end
    end
endmodule // mss_host_model

// ### testbench/tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
    $display("[ERR] %0t value mismatch", $time); end end
module tb;
    localparam int unsigned IC = 16; // Shortened init limit
    logic                  sys_clk_i, rst_n_i, fault_i, ifr_i;
    logic                  pud_i, pdd_i, rsd_i, clr;
    mss_pkg::mss_rst_src_t rs_i;   // Reset sources
    mss_pkg::mss_lp_src_t  lp_i;   // Low-power controls
    logic [7:0]            lanes_i;
    mss_pkg::mss_state_t   st_p, st_f, last_st;
    mss_pkg::mss_ctrl_t    ctrl_p;
    logic                  flag_p, ovr_p, dp_f, dp_p;
    mss_pkg::mss_state_t   exp_q[$]; // Expected state changes
    int                    fails = 0;
    int                    total_checks = 0;
    logic [31:0]           seed = 32'h16;

    // Paged variant, the main object of the run
    mss_sequencer #(.FLAT_MEMORY(1'b0), .INIT_CYCLES(IC)) dut (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .rst_src_i(rs_i),
        .fault_condition_i(fault_i), .lp_src_i(lp_i),
        .lane_path_deactivated_i(lanes_i), .mgmt_if_ready_i(ifr_i),
        .pwr_up_done_i(pud_i), .pwr_dn_done_i(pdd_i),
        .resetting_done_i(rsd_i), .flag_clear_i(clr),
        .module_state_o(st_p), .state_change_flag_o(flag_p),
        .ctrl_o(ctrl_p), .data_path_active_o(dp_p), .init_overrun_o(ovr_p));
    // Flat variant on the same stimulus; only its reported state and data path are watched
    mss_sequencer #(.FLAT_MEMORY(1'b1), .INIT_CYCLES(IC)) dut_flat (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .rst_src_i(rs_i),
        .fault_condition_i(fault_i), .lp_src_i(lp_i),
        .lane_path_deactivated_i(lanes_i), .mgmt_if_ready_i(ifr_i),
        .pwr_up_done_i(pud_i), .pwr_dn_done_i(pdd_i),
        .resetting_done_i(rsd_i), .flag_clear_i(clr),
        .module_state_o(st_f), .state_change_flag_o(), .ctrl_o(),
        .data_path_active_o(dp_f), .init_overrun_o());
    mss_host_model #(.INIT_CYCLES(IC)) host (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .state_change_flag_i(flag_p), .flag_clear_o(clr));

    // Xorshift source for lane patterns
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end

    // Every change of reported state must match the oldest note
    always @(negedge sys_clk_i) begin
        if (rst_n_i && st_p !== last_st) begin
            if (exp_q.size() == 0) `CHK(st_p, last_st)
            else `CHK(st_p, exp_q.pop_front())
            last_st = st_p;
        end
        if (rst_n_i && st_p !== mss_pkg::MSS_RESETTING)
            `CHK(ctrl_p.high_power, st_p inside {mss_pkg::MSS_PWR_UP,
                mss_pkg::MSS_READY, mss_pkg::MSS_PWR_DN})
        `CHK(st_f, mss_pkg::MSS_READY)
        `CHK(dp_f, 1'b1)
        `CHK(dp_p, st_p == mss_pkg::MSS_READY)
    end

    // Bounded wait for a reported state
    task automatic wait_st(input mss_pkg::mss_state_t s);
        for (int i = 0; i < 40; i++) begin
            @(negedge sys_clk_i);
            if (st_p === s) return;
        end
        `CHK(st_p, s)
    endtask

    task automatic go(input mss_pkg::mss_state_t s);
        exp_q.push_back(s);
        wait_st(s);
    endtask

    task automatic wrap_up();
        if (fails == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        #(40 * 3000);
        fails++;
        wrap_up();
    end

    initial begin
        rst_n_i = 1'b0; rs_i = '0; fault_i = 1'b0; ifr_i = 1'b0;
        pud_i = 1'b0; pdd_i = 1'b0; rsd_i = 1'b0; lanes_i = '0;
        lp_i = 3'b100; last_st = mss_pkg::MSS_RESET;
        repeat (5) @(posedge sys_clk_i);
        `CHK(st_p, mss_pkg::MSS_RESET)
        `CHK(ctrl_p, 4'b0110)
        rst_n_i <= 1'b1;
        go(mss_pkg::MSS_MGMT_INIT);
        `CHK(ctrl_p.mgmt_in_reset, 1'b0)
        @(posedge sys_clk_i) ifr_i <= 1'b1;
        go(mss_pkg::MSS_LOW_PWR);
        `CHK(flag_p, 1'b1)
        `CHK({ctrl_p.mgmt_ready, ovr_p}, 2'b10)
        @(posedge sys_clk_i) lp_i <= 3'b000;
        go(mss_pkg::MSS_PWR_UP);
        @(posedge sys_clk_i) pud_i <= 1'b1;
        go(mss_pkg::MSS_READY);
        @(posedge sys_clk_i) lp_i <= 3'b011;
        // Pin request with a lane still busy must not power down
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk_i);
            seed = xs(seed);
            lanes_i <= seed[7:0] & 8'hFE;
        end
        `CHK(st_p, mss_pkg::MSS_READY)
        @(posedge sys_clk_i) lanes_i <= 8'hFF;
        go(mss_pkg::MSS_PWR_DN);
        @(posedge sys_clk_i) pdd_i <= 1'b1;
        go(mss_pkg::MSS_LOW_PWR);
        @(posedge sys_clk_i) fault_i <= 1'b1;
        go(mss_pkg::MSS_FAULT);
        // Fault pin drops while halted; only reset may leave
        @(posedge sys_clk_i) begin
            lp_i    <= 3'b000;
            fault_i <= 1'b0;
        end
        repeat (6) @(posedge sys_clk_i);
        `CHK(flag_p, 1'b0)
        rs_i <= 3'b001;
        go(mss_pkg::MSS_RESETTING);
        `CHK(ctrl_p.elec_in_reset, 1'b1)
        @(posedge sys_clk_i) rsd_i <= 1'b1;
        go(mss_pkg::MSS_RESET);
        @(posedge sys_clk_i) begin
            rsd_i <= 1'b0; fault_i <= 1'b0; ifr_i <= 1'b0; rs_i <= '0;
        end
        go(mss_pkg::MSS_MGMT_INIT);
        repeat (IC + 4) @(posedge sys_clk_i);
        `CHK(ovr_p, 1'b1)
        fault_i <= 1'b1;
        rs_i    <= 3'b010;
        go(mss_pkg::MSS_RESETTING);
        wrap_up();
    end
endmodule // tb
